// *** hw/hsp_host_serial_port.v ***
// Purpose: Device-side serial host port with register read/write access
// Assumes: mclk (20 MHz) is far faster than the serial clock; pins are asynchronous
// Notes: Serial output mirrors serial input outside a read through a registered mux select
//
// Overview of operation
// - Port-select low enables port, high gives JTAG
// - Command word is sixteen bits, MSB first
// - Command holds read/write, auto-increment, 12-bit address
// - Sample bits on serial clock rising edge
// - Auto-increment writes successive words to next addresses
// - Reserved command bits are ignored
// - Read data shifted MSB first
// - First read bit after the command's last rising edge
// - Outside reads, input passes straight to output
// - All selected devices accept chained writes
`include "hsp_map.vh"
`timescale 1ns/1ps
`default_nettype none
module hsp_host_serial_port #(
    parameter WORD_BITS = `HSP_WORD_BITS,
    parameter ADDR_BITS = `HSP_ADDR_BITS
) (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Pins
    input wire port_select_jtag,
    input wire serial_clk,
    input wire chip_select_n,
    input wire serial_in,
    output wire serial_out_loop,
    // JTAG hand-off
    output reg jtag_enable_ff,
    // Register access to device logic
    output reg reg_wr_ff,
    output reg reg_rd_ff,
    output reg [ADDR_BITS-1:0] reg_addr_ff,
    output reg [WORD_BITS-1:0] reg_wdata_ff,
    input wire [WORD_BITS-1:0] reg_rdata,
    // Status
    output reg read_active_ff
);
    // Pin order in the synchroniser bank: clock, chip select, data, port select
    localparam PIN_COUNT = 4;
    // Chip select rests high, so it resets high to avoid a false select
    localparam [PIN_COUNT-1:0] PIN_IDLE = 4'h2;
    wire [PIN_COUNT-1:0] pin_raw;
    wire [PIN_COUNT-1:0] pin_mid;
    wire [PIN_COUNT-1:0] pin_last;
    wire [PIN_COUNT-1:0] pin_state;
    wire sclk_state;
    wire cs_n_state;
    wire sdi_state;
    wire sel_state;
    wire port_owned;
    wire sclk_rise;
    wire sclk_fall;
    wire [WORD_BITS-1:0] word_in;
    wire word_done;
    wire [ADDR_BITS-1:0] addr_step;
    reg [3:0] bit_cnt_ff;
    reg [WORD_BITS-1:0] shift_in_ff;
    reg [WORD_BITS-1:0] shift_out_ff;
    reg have_cmd_ff;
    reg cmd_ainc_ff;
    reg out_bit_ff;
    reg nxt_jtag_enable;
    reg nxt_reg_wr;
    reg nxt_reg_rd;
    reg [ADDR_BITS-1:0] nxt_reg_addr;
    reg [WORD_BITS-1:0] nxt_reg_wdata;
    reg nxt_read_active;
    reg [3:0] nxt_bit_cnt;
    reg [WORD_BITS-1:0] nxt_shift_in;
    reg [WORD_BITS-1:0] nxt_shift_out;
    reg nxt_have_cmd;
    reg nxt_cmd_ainc;
    reg nxt_out_bit;

    assign pin_raw = {port_select_jtag, serial_in, chip_select_n, serial_clk};

    // Three-stage synchronisers; only stages two and three are compared
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin_sync
            reg [2:0] sync_ff;
            reg state_ff;
            always @(posedge mclk) begin
                if (reset) begin
                    sync_ff <= {3{PIN_IDLE[gi]}};
                    state_ff <= PIN_IDLE[gi];
                end else begin
                    sync_ff <= {sync_ff[1:0], pin_raw[gi]};
                    // A level counts once the last two stages agree
                    if (sync_ff[1] == sync_ff[2])
                        state_ff <= sync_ff[2];
                end
            end
            assign pin_mid[gi] = sync_ff[1];
            assign pin_last[gi] = sync_ff[2];
            assign pin_state[gi] = state_ff;
        end
    endgenerate

    assign sclk_state = pin_state[0];
    assign cs_n_state = pin_state[1];
    assign sdi_state = pin_state[2];
    assign sel_state = pin_state[3];
    assign port_owned = !sel_state && !cs_n_state;

    // Edges of the bursty serial clock, only while this port owns the pins
    assign sclk_rise = pin_mid[0] && pin_last[0] && !sclk_state && port_owned;
    assign sclk_fall = !pin_mid[0] && !pin_last[0] && sclk_state && port_owned;
    assign word_in = {shift_in_ff[WORD_BITS-2:0], sdi_state};
    assign word_done = sclk_rise && (bit_cnt_ff == `HSP_BITCNT_LAST);
    assign addr_step = {{(ADDR_BITS-1){1'b0}}, cmd_ainc_ff};

    always @* begin
        nxt_jtag_enable = sel_state;
        nxt_reg_wr = 1'b0;
        nxt_reg_rd = 1'b0;
        nxt_reg_addr = reg_addr_ff;
        nxt_reg_wdata = reg_wdata_ff;
        nxt_read_active = read_active_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift_in = shift_in_ff;
        nxt_shift_out = shift_out_ff;
        nxt_have_cmd = have_cmd_ff;
        nxt_cmd_ainc = cmd_ainc_ff;
        nxt_out_bit = out_bit_ff;
        if (!port_owned) begin
            // Deselect ends any access and drops half-received words
            nxt_bit_cnt = `HSP_BITCNT_RST;
            nxt_have_cmd = 1'b0;
            nxt_read_active = 1'b0;
        end else begin
            if (sclk_rise) begin
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
                nxt_shift_in = word_in;
            end
            if (word_done && !have_cmd_ff) begin
                // Reserved bits 14..13 are never looked at
                nxt_have_cmd = 1'b1;
                nxt_cmd_ainc = word_in[`HSP_CMD_AINC_BIT];
                nxt_reg_addr = word_in[`HSP_CMD_ADDR_MSB:0];
                if (word_in[`HSP_CMD_RW_BIT]) begin
                    nxt_read_active = 1'b1;
                    nxt_reg_rd = 1'b1;
                end
            end else if (word_done && !read_active_ff) begin
                // Every selected device writes, so chained writes land together
                nxt_reg_wr = 1'b1;
                nxt_reg_wdata = word_in;
                nxt_have_cmd = cmd_ainc_ff;
            end else if (word_done) begin
                nxt_have_cmd = cmd_ainc_ff;
                nxt_read_active = cmd_ainc_ff;
                nxt_reg_rd = cmd_ainc_ff;
            end
            // With auto-increment set, address steps the cycle after each access strobe
            if (reg_wr_ff || reg_rd_ff)
                nxt_reg_addr = reg_addr_ff + addr_step;
            if (reg_rd_ff) begin
                // Read data lands a cycle after the strobe; MSB goes out at once
                nxt_shift_out = {reg_rdata[WORD_BITS-2:0], 1'b0};
                nxt_out_bit = reg_rdata[WORD_BITS-1];
            end else if (sclk_fall && read_active_ff && bit_cnt_ff != `HSP_BITCNT_RST) begin
                nxt_out_bit = shift_out_ff[WORD_BITS-1];
                nxt_shift_out = {shift_out_ff[WORD_BITS-2:0], 1'b0};
            end
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            jtag_enable_ff <= 1'b0;
            reg_wr_ff <= 1'b0;
            reg_rd_ff <= 1'b0;
            reg_addr_ff <= `HSP_ADDR_RST;
            reg_wdata_ff <= `HSP_DATA_RST;
            read_active_ff <= 1'b0;
            bit_cnt_ff <= `HSP_BITCNT_RST;
            shift_in_ff <= `HSP_DATA_RST;
            shift_out_ff <= `HSP_DATA_RST;
            have_cmd_ff <= 1'b0;
            cmd_ainc_ff <= 1'b0;
            out_bit_ff <= 1'b0;
        end else begin
            jtag_enable_ff <= nxt_jtag_enable;
            reg_wr_ff <= nxt_reg_wr;
            reg_rd_ff <= nxt_reg_rd;
            reg_addr_ff <= nxt_reg_addr;
            reg_wdata_ff <= nxt_reg_wdata;
            read_active_ff <= nxt_read_active;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_in_ff <= nxt_shift_in;
            shift_out_ff <= nxt_shift_out;
            have_cmd_ff <= nxt_have_cmd;
            cmd_ainc_ff <= nxt_cmd_ainc;
            out_bit_ff <= nxt_out_bit;
        end
    end

    // Loop-through is a pure wire path for zero-latency chaining; only the select is registered
    assign serial_out_loop = read_active_ff ? out_bit_ff : serial_in;
endmodule
`default_nettype wire

// *** hw/hsp_map.vh ***
// Purpose: Constants for the host serial port
// Assumes: Included by hsp_host_serial_port.v
// Notes: Command word layout and widths
`ifndef HSP_MAP_VH
`define HSP_MAP_VH
`define HSP_WORD_BITS 16
`define HSP_CMD_RW_BIT 15
`define HSP_CMD_AINC_BIT 12
`define HSP_CMD_ADDR_MSB 11
`define HSP_ADDR_BITS 12
`define HSP_BITCNT_LAST 4'hf
`define HSP_BITCNT_RST 4'h0
`define HSP_ADDR_RST 12'h000
`define HSP_DATA_RST 16'h0000
`endif

// *** dv/hsp_props_properties.sv ***
// Purpose: Port-level checks for the host serial port
// Assumes: Bound to hsp_host_serial_port, single mclk domain
// Notes: Pin latency is a few mclk, so windows allow 8
`timescale 1ns/1ps
`default_nettype none
module hsp_props (
    // Clock, reset, pins
    input wire mclk, input wire reset, input wire port_select_jtag,
    input wire chip_select_n, input wire serial_in, input wire serial_out_loop,
    // Device side
    input wire jtag_enable_ff, input wire reg_wr_ff, input wire reg_rd_ff,
    input wire [11:0] reg_addr_ff, input wire read_active_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_wr_single: assert property (reg_wr_ff |=> !reg_wr_ff)
        else $error("write strobe too long");
    chk_rd_single: assert property (reg_rd_ff |=> !reg_rd_ff)
        else $error("read strobe too long");
    chk_wr_rd_apart: assert property (!(reg_wr_ff && reg_rd_ff))
        else $error("write and read together");
    chk_jtag_follow: assert property ($rose(port_select_jtag) |-> ##[1:8] jtag_enable_ff)
        else $error("jtag hand-off late");
    chk_jtag_quiet: assert property (jtag_enable_ff |-> !reg_wr_ff && !reg_rd_ff)
        else $error("access while jtag owns pins");
    // Mux select is registered, so the cycles around a read are left out
    chk_loop_through: assert property (
        !read_active_ff && !$past(read_active_ff) && !reg_rd_ff
        && !$past(reg_rd_ff) && !$past(reg_rd_ff, 2) |-> serial_out_loop == serial_in)
        else $error("serial out not a copy of serial in");
    chk_desel_idle: assert property (chip_select_n [*8] |=> !reg_wr_ff && !reg_rd_ff)
        else $error("access while deselected");
    chk_reset_quiet: assert property ($fell(reset) |-> !reg_wr_ff && !read_active_ff)
        else $error("outputs not cleared by reset");
    chk_addr_step: assert property (
        reg_wr_ff ##1 reg_addr_ff != $past(reg_addr_ff)
        |-> reg_addr_ff == $past(reg_addr_ff) + 12'h001)
        else $error("address step not one");
    cover property (reg_wr_ff);
    cover property (reg_rd_ff);
    cover property (jtag_enable_ff);
endmodule
`default_nettype wire

// *** dv/hsp_host_model.sv ***
// Purpose: Host side of the serial chain
// Assumes: 400 ns serial clock, bursts only inside frames
// Notes: Released data line shows the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model (
    // Pins
    output logic serial_clk, output logic chip_select_n, output logic serial_in,
    input wire serial_out_loop
);
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        for (int i = 15; i >= 0; i--) begin
            serial_in = w[i];
            #200 serial_clk = 1'b1;
            r[i] = serial_out_loop;
            #200 serial_clk = 1'b0;
        end
        serial_in = ~w[0];
        #400;
    endtask
    // Command first, then n data words counting up from d
    task automatic frame(input logic [15:0] c, input logic [15:0] d, input int n,
        output logic [15:0] r);
        // Only one device hangs on this chain, so one select at a time
        #7 chip_select_n = 1'b0;
        #100 xfer(c, r);
        for (int k = 0; k < n; k++) xfer(d + k[15:0], r);
        chip_select_n = 1'b1;
        // Deselect must outlast the pin filter or the port never sees it
        #400;
    endtask
endmodule
`default_nettype wire

// *** dv/hsp_host_serial_port_bench.sv ***
// Purpose: Self-checking bench for the host serial port
// Assumes: Read data is the address with a marker nibble
// Notes: Deselect mid-word is left to the checker
`timescale 1ns/1ps
`default_nettype none
module hsp_host_serial_port_bench;
    logic mclk, reset, port_select_jtag, serial_clk, chip_select_n, serial_in;
    wire serial_out_loop, jtag_enable_ff, reg_wr_ff, reg_rd_ff, read_active_ff;
    wire [11:0] reg_addr_ff;
    wire [15:0] reg_wdata_ff, reg_rdata;
    logic [15:0] got;
    logic [27:0] wq[$];
    int fail_count, cmp_count, cycles;
    hsp_host_serial_port uut (
        .mclk(mclk),
        .reset(reset),
        .port_select_jtag(port_select_jtag),
        .serial_clk(serial_clk),
        .chip_select_n(chip_select_n),
        .serial_in(serial_in),
        .serial_out_loop(serial_out_loop),
        .jtag_enable_ff(jtag_enable_ff),
        .reg_wr_ff(reg_wr_ff),
        .reg_rd_ff(reg_rd_ff),
        .reg_addr_ff(reg_addr_ff),
        .reg_wdata_ff(reg_wdata_ff),
        .reg_rdata(reg_rdata),
        .read_active_ff(read_active_ff)
    );
    hsp_host_model host (
        .serial_clk(serial_clk),
        .chip_select_n(chip_select_n),
        .serial_in(serial_in),
        .serial_out_loop(serial_out_loop)
    );
    assign reg_rdata = {4'ha, reg_addr_ff};
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (reg_wr_ff === 1'b1) wq.push_back({reg_addr_ff, reg_wdata_ff});
        if (cycles == 4000) begin
            fail_count++;
            give_verdict;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_write;
        host.frame(16'h6123, 16'hbeef, 1, got);
        check(got, 16'hbeef);
        check(wq.size(), 32'h1);
        check(wq.pop_front(), {12'h123, 16'hbeef});
        $display("write test done");
    endtask
    task automatic t_auto;
        host.frame(16'h1ffe, 16'h1111, 2, got);
        check(wq.pop_front(), {12'hffe, 16'h1111});
        check(wq.pop_front(), {12'hfff, 16'h1112});
        $display("auto-increment test done");
    endtask
    task automatic t_read;
        // Follows an auto-increment frame, so the command must start afresh
        host.frame(16'h8045, 16'h0000, 1, got);
        check(got, 16'ha045);
        check(wq.size(), 32'h0);
        check(read_active_ff, 1'b0);
        $display("read test done");
    endtask
    task automatic t_jtag;
        @(posedge mclk);
        port_select_jtag <= 1'b1;
        repeat (10) @(posedge mclk);
        check(jtag_enable_ff, 1'b1);
        host.frame(16'h0001, 16'h5555, 1, got);
        check(wq.size(), 32'h0);
        port_select_jtag <= 1'b0;
        $display("jtag test done");
    endtask
    initial begin
        reset = 1'b1;
        port_select_jtag = 1'b0;
        cycles = 0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        t_write;
        t_auto;
        t_read;
        t_jtag;
        give_verdict;
    end
endmodule
bind hsp_host_serial_port hsp_props chk (
    .mclk(mclk),
    .reset(reset),
    .port_select_jtag(port_select_jtag),
    .chip_select_n(chip_select_n),
    .serial_in(serial_in),
    .serial_out_loop(serial_out_loop),
    .jtag_enable_ff(jtag_enable_ff),
    .reg_wr_ff(reg_wr_ff),
    .reg_rd_ff(reg_rd_ff),
    .reg_addr_ff(reg_addr_ff),
    .read_active_ff(read_active_ff)
);
`default_nettype wire
